// ---- logic/hpb_regs.vh ----
`ifndef HPB_REGS_VH
`define HPB_REGS_VH
// Notes on behaviour
// - power sense high means host on
// - power drive tri-stated except during actions
// - reset drive tri-stated except during reset
// - check held 0.25 s powers on
// - cancel held 4 s forces off
// - held cancel extends off pulse 5 s
// - check held 4 s resets host 1 s
// - self restart after keypad reset pulse
// - blank display while host is off
// - hold fan settings while host off
// - reset output shared with watchdog
`define HPB_CLK_HZ        25000000
`define HPB_MS_DIV        25000
`define HPB_ON_HOLD_MS    250
`define HPB_OFF_HOLD_MS   4000
`define HPB_RST_HOLD_MS   4000
`define HPB_EXTEND_MS     5000
`define HPB_RST_PULSE_MS  1000
`define HPB_PULSE_DEF_MS  1000
`endif

// ---- logic/hpb_ms_tick.v ----
`timescale 1ns/10ps
`include "hpb_regs.vh"
// divider that makes a one-cycle enable every millisecond
module hpb_ms_tick
#(
   parameter DIV = `HPB_MS_DIV
)
(
   input  wire clock,
   input  wire rst_n,
   output reg  tick
);
   reg [15:0] count;

   // free running; the phase of the first tick is not significant
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (count == DIV[15:0] - 16'h0001)
      begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

// ---- logic/hpb_power_button.v ----
`timescale 1ns/10ps
`include "hpb_regs.vh"
// keypad driven power on, hard power off and host reset sequencer
module hpb_power_button
#(
   parameter MS_DIV       = `HPB_MS_DIV,
   parameter ON_HOLD_MS   = `HPB_ON_HOLD_MS,
   parameter OFF_HOLD_MS  = `HPB_OFF_HOLD_MS,
   parameter RST_HOLD_MS  = `HPB_RST_HOLD_MS,
   parameter EXTEND_MS    = `HPB_EXTEND_MS,
   parameter RST_PULSE_MS = `HPB_RST_PULSE_MS
)
(
   input  wire        clock,
   input  wire        rst_n,
   input  wire        power_sense,
   input  wire        key_check,
   input  wire        key_cancel,
   input  wire        enable_power_on,
   input  wire        enable_power_off,
   input  wire        enable_reset,
   input  wire        power_invert,
   input  wire        reset_invert,
   input  wire        blank_when_off,
   input  wire [15:0] pulse_ms,
   input  wire        watchdog_reset,
   input  wire [7:0]  fan_power_in,
   output reg         power_drive_out,
   output reg         power_drive_oe_n,
   output reg         reset_drive_out,
   output reg         reset_drive_oe_n,
   output reg         display_blank,
   output reg  [7:0]  fan_power_out,
   output reg         self_restart
);
   // one-hot sequencer states
   localparam [5:0] ST_IDLE   = 6'h01;
   localparam [5:0] ST_ONHOLD = 6'h02;
   localparam [5:0] ST_OFFHLD = 6'h04;
   localparam [5:0] ST_RSTHLD = 6'h08;
   localparam [5:0] ST_PWRPLS = 6'h10;
   localparam [5:0] ST_RSTPLS = 6'h20;

   wire        ms;
   reg  [5:0]  state;
   // one counter serves every hold and pulse; each state starts it at zero
   reg  [15:0] ms_count;
   reg         hard_off;
   wire [15:0] pulse_min;
   wire        want_on;
   wire        want_off;
   wire        want_rst;
   wire        pwr_min_done;
   wire        pwr_cap_done;

   // true on the tick that completes a span of limit milliseconds
   function span_done;
      input [15:0] count;
      input [15:0] limit;
      begin
         span_done = (count == limit - 16'h0001);
      end
   endfunction

   // a zero pulse setting would release the line on the first tick, so use one ms
   assign pulse_min = (pulse_ms == 16'h0000) ? 16'h0001 : pulse_ms;

   // press decodes; sense low means host off, high means on
   assign want_on  = !power_sense && key_check && enable_power_on;
   assign want_off = power_sense && key_cancel && enable_power_off;
   assign want_rst = power_sense && key_check && enable_reset;

   // entry is always on a tick, so the one extra tick makes the power
   // pulse one millisecond longer than the set width; the cap stays at width plus
   // extension, and settings near the top of the range shorten it
   assign pwr_min_done = (ms_count >= pulse_min);
   assign pwr_cap_done = (ms_count >= pulse_min + EXTEND_MS[15:0] - 16'h0001);

   // one millisecond enable paces every hold and pulse
   hpb_ms_tick #(.DIV(MS_DIV)) u_tick
   (
      .clock (clock),
      .rst_n (rst_n),
      .tick  (ms)
   );

   // hold timing and pulse sequencing
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= ST_IDLE;
         ms_count     <= 16'h0000;
         hard_off     <= 1'b0;
         self_restart <= 1'b0;
      end
      else
      begin
         self_restart <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               // counter cleared here so each hold starts from zero
               ms_count <= 16'h0000;
               hard_off <= 1'b0;
               // priority: power on, then hard off, then reset
               if (want_on)
                  state <= ST_ONHOLD;
               else if (want_off)
                  state <= ST_OFFHLD;
               else if (want_rst)
                  state <= ST_RSTHLD;
            end
            ST_ONHOLD:
            begin
               // letting go or a change of host state drops the hold
               if (!key_check || power_sense)
                  state <= ST_IDLE;
               else if (ms && span_done(ms_count, ON_HOLD_MS[15:0]))
               begin
                  ms_count <= 16'h0000;
                  state    <= ST_PWRPLS;
               end
               else if (ms)
                  ms_count <= ms_count + 16'h0001;
            end
            ST_OFFHLD:
            begin
               // letting go or a change of host state drops the hold
               if (!key_cancel || !power_sense)
                  state <= ST_IDLE;
               else if (ms && span_done(ms_count, OFF_HOLD_MS[15:0]))
               begin
                  ms_count <= 16'h0000;
                  hard_off <= 1'b1;
                  state    <= ST_PWRPLS;
               end
               else if (ms)
                  ms_count <= ms_count + 16'h0001;
            end
            ST_RSTHLD:
            begin
               // letting go or a change of host state drops the hold
               if (!key_check || !power_sense)
                  state <= ST_IDLE;
               else if (ms && span_done(ms_count, RST_HOLD_MS[15:0]))
               begin
                  ms_count <= 16'h0000;
                  state    <= ST_RSTPLS;
               end
               else if (ms)
                  ms_count <= ms_count + 16'h0001;
            end
            ST_PWRPLS:
            begin
               // hard off keeps driving while cancel held, capped
               if (ms && pwr_min_done &&
                   (!hard_off || !key_cancel || pwr_cap_done))
               begin
                  ms_count <= 16'h0000;
                  state    <= ST_IDLE;
               end
               else if (ms)
                  ms_count <= ms_count + 16'h0001;
            end
            ST_RSTPLS:
            begin
               // restart request rides the last edge; the line frees one cycle later
               if (ms && span_done(ms_count, RST_PULSE_MS[15:0]))
               begin
                  ms_count     <= 16'h0000;
                  self_restart <= 1'b1;
                  state        <= ST_IDLE;
               end
               else if (ms)
                  ms_count <= ms_count + 16'h0001;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // pin drivers: released unless a pulse is in progress or, for reset, the watchdog holds reset
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_drive_oe_n <= 1'b1;
         power_drive_out  <= 1'b0;
         reset_drive_oe_n <= 1'b1;
         reset_drive_out  <= 1'b0;
      end
      else
      begin
         // power pulse is masked while the watchdog holds reset; its timer keeps running, so the pulse is cut short rather than delayed
         power_drive_oe_n <= ~((state == ST_PWRPLS) && !watchdog_reset);
         power_drive_out  <= ~power_invert;
         // a watchdog reset merges with a keypad reset rather than queueing
         // keypad and watchdog share one reset line
         reset_drive_oe_n <= ~((state == ST_RSTPLS) || watchdog_reset);
         reset_drive_out  <= ~reset_invert;
      end
   end

   // display blank and fan hold while the host is off
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         display_blank <= 1'b0;
         fan_power_out <= 8'h00;
      end
      else
      begin
         display_blank <= blank_when_off && !power_sense;
         // frozen rather than cleared, so fans on a live supply keep running
         if (power_sense)
            fan_power_out <= fan_power_in; // frozen while off
      end
   end
endmodule

// ---- testbench/hpb_power_button_sva.sv ----
`timescale 1ns/10ps
// watches the pin drivers and status outputs of the sequencer
module hpb_power_button_sva
(
   input wire       clock,
   input wire       rst_n,
   input wire       power_sense,
   input wire       enable_power_on,
   input wire       enable_power_off,
   input wire       enable_reset,
   input wire       power_invert,
   input wire       reset_invert,
   input wire       blank_when_off,
   input wire       watchdog_reset,
   input wire [7:0] fan_power_in,
   input wire       power_drive_out,
   input wire       power_drive_oe_n,
   input wire       reset_drive_out,
   input wire       reset_drive_oe_n,
   input wire       display_blank,
   input wire [7:0] fan_power_out,
   input wire       self_restart
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // widths assume a 4 cycle tick, a 4 ms reset pulse and a 4 ms power-on pulse from the 3 ms width setting
   chk_never_both: assert property (power_drive_oe_n || reset_drive_oe_n)
      else $error("both pins driven");
   chk_pwr_level: assert property (!power_drive_oe_n |-> power_drive_out == !power_invert)
      else $error("power level");
   chk_rst_level: assert property (!reset_drive_oe_n |-> reset_drive_out == !reset_invert)
      else $error("reset level");
   chk_pwr_cause: assert property ($fell(power_drive_oe_n) |->
      $past(enable_power_on && !power_sense || enable_power_off && power_sense))
      else $error("power cause");
   chk_rst_cause: assert property ($fell(reset_drive_oe_n) |->
      $past(watchdog_reset || enable_reset && power_sense)) else $error("reset cause");
   chk_rst_width: assert property ($fell(reset_drive_oe_n) && !watchdog_reset |->
      !reset_drive_oe_n[*8] ##[1:16] reset_drive_oe_n) else $error("reset width");
   chk_on_width: assert property ($fell(power_drive_oe_n) && !power_sense |->
      !power_drive_oe_n[*8] ##[1:12] power_drive_oe_n) else $error("power width");
   chk_restart_end: assert property (self_restart |=> reset_drive_oe_n && !self_restart)
      else $error("restart pulse");
   chk_blank_off: assert property ($past(rst_n) |->
      display_blank == $past(blank_when_off && !power_sense)) else $error("blank");
   chk_fan_hold: assert property ($past(rst_n) |-> fan_power_out ==
      ($past(power_sense) ? $past(fan_power_in) : $past(fan_power_out))) else $error("fan");
endmodule
bind hpb_power_button hpb_power_button_sva i_sva (.clock, .rst_n, .power_sense,
   .enable_power_on, .enable_power_off, .enable_reset, .power_invert, .reset_invert,
   .blank_when_off, .watchdog_reset, .fan_power_in, .power_drive_out, .power_drive_oe_n,
   .reset_drive_out, .reset_drive_oe_n, .display_blank, .fan_power_out, .self_restart);

// ---- testbench/hpb_board.sv ----
`timescale 1ns/10ps
// motherboard switch inputs; no pull, so a released pin toggles each cycle
module hpb_board
(
   input  wire clock,
   input  wire pwr_d,
   input  wire pwr_oe_n,
   input  wire rst_d,
   input  wire rst_oe_n,
   output reg  pwr_pin,
   output reg  rst_pin
);
   initial
   begin
      pwr_pin = 1'b0;
      rst_pin = 1'b0;
   end
   // the pin shows the driven level only while its enable is low
   always @(posedge clock)
   begin
      pwr_pin <= pwr_oe_n ? ~pwr_pin : pwr_d;
      rst_pin <= rst_oe_n ? ~rst_pin : rst_d;
   end
endmodule

// ---- testbench/test_hpb_power_button.sv ----
`timescale 1ns/10ps
module test_hpb_power_button;
   reg        clock, rst_n, ps, kc, kx, eon, eoff, er, pi, ri, bw, wd, srs;
   reg  [7:0] fi;
   reg  [1:0] pv;
   reg  [15:0] pw;
   wire       pd, po, rd, ro, db, sr, bp, br;
   wire [7:0] fo;
   integer    mismatches, samples_checked, w, i;
   // short tick and holds keep the run short; power-on hold stays at its default
   hpb_power_button #(.MS_DIV(4), .OFF_HOLD_MS(8), .RST_HOLD_MS(8),
      .EXTEND_MS(6), .RST_PULSE_MS(4)) i_dut (.clock(clock), .rst_n(rst_n),
      .power_sense(ps), .key_check(kc), .key_cancel(kx), .enable_power_on(eon),
      .enable_power_off(eoff), .enable_reset(er), .power_invert(pi), .reset_invert(ri),
      .blank_when_off(bw), .pulse_ms(pw), .watchdog_reset(wd), .fan_power_in(fi),
      .power_drive_out(pd), .power_drive_oe_n(po), .reset_drive_out(rd),
      .reset_drive_oe_n(ro), .display_blank(db), .fan_power_out(fo), .self_restart(sr));
   // the control pins go straight to the board; the test also reads the enables po and ro
   hpb_board i_board (.clock(clock), .pwr_d(pd), .pwr_oe_n(po), .rst_d(rd),
      .rst_oe_n(ro), .pwr_pin(bp), .rst_pin(br));
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task chk(input logic s, input logic e);
      samples_checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %0t got %b", $time, s);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // hold a key through the whole pulse, then measure its width in cycles
   task pulse(input logic k);
      w = 0;
      srs = 0;
      kc = k;
      kx = !k;
      for (i = 0; i < 1500 && po && ro; i++) tick(1);
      for (i = 0; i < 400 && !(po && ro); i++)
      begin
         tick(1);
         w++;
         srs = srs | sr;
         if (w == 3) pv = {bp, br};
      end
      kc = 0;
      kx = 0;
   endtask
   // press check for hold cycles; nothing may be driven
   task t_quiet(input integer hold);
      for (i = 0; i < 100; i++)
      begin
         kc = i < hold;
         tick(1);
         chk(po && ro, 1'b1);
      end
   endtask
   initial
   begin
      {rst_n, ps, kc, kx, eon, eoff, er, pi, ri, bw, wd} = 0;
      fi = 8'h00;
      pw = 16'h0003;
      mismatches = 0;
      samples_checked = 0;
      tick(16);
      rst_n = 1;
      {ps, bw, fi} = {2'b11, 8'h5a};
      tick(3);
      {ps, fi} = {1'b0, 8'ha5};
      tick(3);
      chk(fo === 8'h5a && db, 1'b1);
      t_quiet(100);
      eon = 1;
      t_quiet(8);
      pulse(1);
      chk(w >= 12 && w <= 16 && pv[1], 1'b1);
      {ps, eoff, pi} = 3'b111;
      pw = 16'h0002;
      tick(3);
      chk(fo === 8'ha5 && !db, 1'b1);
      pulse(0);
      chk(w >= 28 && w <= 44 && !pv[1], 1'b1);
      {eoff, er, ri} = 3'b011;
      pulse(1);
      chk(w >= 12 && w <= 20 && srs && !pv[0], 1'b1);
      wd = 1;
      tick(4);
      chk(ro, 1'b0);
      rst_n = 0;
      tick(2);
      chk(ro && po && fo === 8'h00, 1'b1);
      rst_n = 1;
      tick(2);
      chk(ro, 1'b0);
      wd = 0;
      tick(4);
      chk(ro && po, 1'b1);
      close_out;
   end
   initial
   begin
      #400000;
      mismatches++;
      close_out;
   end
endmodule
